// ==== lmzp_defs.svh ====
/*
 * Constants for the mode-register, impedance calibration and power-down block.
 * Assumes inclusion by the package and the design modules of this block.
 */
`ifndef LMZP_DEFS_SVH
`define LMZP_DEFS_SVH

`define LMZP_CLK_PERIOD_NS 10
`define LMZP_CA_W 10
`define LMZP_DQ_W 32
`define LMZP_PAT_A_ADDR 8'h20
`define LMZP_PAT_B_ADDR 8'h28
`define LMZP_PAT_A 4'h5
`define LMZP_PAT_B 4'hC
`define LMZP_RESET_ADDR 8'h3F
`define LMZP_RESET_DATA 8'hFC
`define LMZP_CAL_ADDR 8'h0A
`define LMZP_ZQ_INIT 8'hFF
`define LMZP_ZQ_LONG 8'hAB
`define LMZP_ZQ_SHORT 8'h56
`define LMZP_ZQ_RESET 8'hC3
`define LMZP_ROREG_LO 8'h04
`define LMZP_ROREG_HI 8'h08
`define LMZP_NUM_REGS 64
`define LMZP_MRR_CYC 2
`define LMZP_MRW_CYC 5
`define LMZP_INIT_CYC 100
`define LMZP_IMPEDANCE_CAL_INIT_CYC 100
`define LMZP_IMPEDANCE_CAL_LONG_CYC 36
`define LMZP_IMPEDANCE_CAL_SHORT_CYC 9
`define LMZP_ZQRST_CYC 5
`define LMZP_CKE_CYC 3
`define LMZP_XP_CYC 3
`define LMZP_RL_CYC 3
`define LMZP_BURST 4

`endif

// ==== lmzp_pkg.sv ====
/*
 * Types for the mode-register, calibration and power-down block.
 * Assumes lmzp_defs.svh is available.
 */
`include "lmzp_defs.svh"

package lmzp_pkg;

	typedef enum logic [2:0] {
		LMZP_IDLE = 3'b000,
		LMZP_MRR = 3'b001,
		LMZP_MRW = 3'b011,
		LMZP_INIT = 3'b010,
		LMZP_ZQ = 3'b110,
		LMZP_PD = 3'b111,
		LMZP_XP = 3'b101
	} lmzp_state_t;

	typedef struct packed {
		logic cs_n;
		logic cke;
		logic [`LMZP_CA_W-1:0] ca_rise;
		logic [`LMZP_CA_W-1:0] ca_fall;
	} lmzp_cmd_t;

	typedef struct packed {
		logic in_pd;
		logic active_pd;
		logic busy;
		logic zq_pin_en;
		logic zq_done;
	} lmzp_stat_t;

endpackage : lmzp_pkg

// ==== lmzp_mreg_mem.sv ====
/*
 * Small mode-register store with registered read data.
 * Assumes one clock domain; a clear writes every entry to its default.
 */
`timescale 1ns/1ns
`include "lmzp_defs.svh"

module lmzp_mreg_mem #(
	parameter int DEPTH = `LMZP_NUM_REGS,
	parameter int AW = 6
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic en,
	input wire logic clr,
	input wire logic we,
	input wire logic [AW-1:0] waddr,
	input wire logic [7:0] wdata,
	input wire logic [AW-1:0] raddr,
	output logic [7:0] rdata
);

	logic [7:0] mem_q [DEPTH];

	genvar gi;
	generate
		for (gi = 0; gi < DEPTH; gi++)
		begin : g_ent
			always_ff @(posedge clk or negedge rst_n)
			begin
				if (!rst_n)
					mem_q[gi] <= 8'h00;
				else if (en && clr)
					mem_q[gi] <= 8'h00;
				else if (en && we && waddr == AW'(gi))
					mem_q[gi] <= wdata;
			end
		end
	endgenerate

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			rdata <= 8'h00;
		else if (en)
			rdata <= mem_q[raddr];
	end

endmodule : lmzp_mreg_mem

// ==== lmzp_core.sv ====
/*
 * Device-side command decode for mode-register read/write, reset,
 * impedance calibration and power-down of a low-power DRAM.
 * Assumes command pins already registered on clk by the pad logic and a
 * controller that keeps the no-operation and timing duties it owns.
 */
`timescale 1ns/1ns
`include "lmzp_defs.svh"

module lmzp_core #(
	parameter int DQ_W = `LMZP_DQ_W,
	parameter int MRR_CYC = `LMZP_MRR_CYC,
	parameter int MRW_CYC = `LMZP_MRW_CYC,
	parameter int INIT_CYC = `LMZP_INIT_CYC,
	parameter int IMPEDANCE_CAL_INIT_CYC = `LMZP_IMPEDANCE_CAL_INIT_CYC,
	parameter int IMPEDANCE_CAL_LONG_CYC = `LMZP_IMPEDANCE_CAL_LONG_CYC,
	parameter int IMPEDANCE_CAL_SHORT_CYC = `LMZP_IMPEDANCE_CAL_SHORT_CYC,
	parameter int ZQRST_CYC = `LMZP_ZQRST_CYC,
	parameter int CKE_CYC = `LMZP_CKE_CYC,
	parameter int XP_CYC = `LMZP_XP_CYC
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire lmzp_pkg::lmzp_cmd_t cmd,
	input wire logic any_bank_open,
	input wire logic zq_strap_vdd,
	output logic [DQ_W-1:0] dq_out,
	output logic dq_oe,
	output logic [`LMZP_BURST-1:0] pat_beats,
	output logic refresh_allow,
	output logic in_buf_en,
	output lmzp_pkg::lmzp_stat_t stat
);

	localparam int CW = 16;

	// ****************************************************************
	// Command decode
	// ****************************************************************
	lmzp_pkg::lmzp_state_t state_q;
	logic [CW-1:0] cnt_q;
	logic [7:0] ma;
	logic [7:0] op;
	logic is_mrr;
	logic is_mrw;
	logic cmd_ok;
	logic ro_reg;
	logic is_pat;
	logic zq_cmd;
	logic strap_meta_q;
	logic strap_q;

	assign cmd_ok = (state_q == lmzp_pkg::LMZP_IDLE) && cmd.cke;
	assign is_mrr = cmd_ok && !cmd.cs_n && cmd.ca_rise[3:0] == 4'h8;
	assign is_mrw = cmd_ok && !cmd.cs_n && cmd.ca_rise[3:0] == 4'h0;
	assign ma = {cmd.ca_rise[9:4], cmd.ca_fall[1:0]};
	assign op = cmd.ca_fall[9:2];
	assign ro_reg = (ma >= `LMZP_ROREG_LO && ma <= `LMZP_ROREG_HI) || ma == `LMZP_PAT_A_ADDR
		|| ma == `LMZP_PAT_B_ADDR;
	assign is_pat = ma == `LMZP_PAT_A_ADDR || ma == `LMZP_PAT_B_ADDR;
	assign zq_cmd = is_mrw && ma == `LMZP_CAL_ADDR && !strap_q;

	// Strap pin passes two flops; only the second one is read
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			strap_meta_q <= 1'b0;
			strap_q <= 1'b0;
		end
		else if (clk_en)
		begin
			strap_meta_q <= zq_strap_vdd;
			strap_q <= strap_meta_q;
		end
	end

	// ****************************************************************
	// Mode-register store
	// ****************************************************************
	logic [7:0] rdata;
	logic mem_clr;
	logic [5:0] raddr_q;

	assign mem_clr = is_mrw && ma == `LMZP_RESET_ADDR && op == `LMZP_RESET_DATA;

	// Read address held so the first beat shows the addressed register
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			raddr_q <= 6'h00;
		else if (clk_en && is_mrr)
			raddr_q <= ma[5:0];
	end

	lmzp_mreg_mem #(
		.DEPTH(`LMZP_NUM_REGS),
		.AW(6)
	) u_mem (
		.clk(clk),
		.rst_n(rst_n),
		.en(clk_en),
		.clr(mem_clr),
		.we(is_mrw && !ro_reg && !mem_clr),
		.waddr(ma[5:0]),
		.wdata(op),
		.raddr(raddr_q),
		.rdata(rdata)
	);

	// ****************************************************************
	// State and period counter
	// ****************************************************************
	logic [CW-1:0] zq_len;

	always_comb
	begin
		zq_len = CW'(ZQRST_CYC);
		unique case (op)
			`LMZP_ZQ_INIT: zq_len = CW'(IMPEDANCE_CAL_INIT_CYC);
			`LMZP_ZQ_LONG: zq_len = CW'(IMPEDANCE_CAL_LONG_CYC);
			`LMZP_ZQ_SHORT: zq_len = CW'(IMPEDANCE_CAL_SHORT_CYC);
			default: zq_len = CW'(ZQRST_CYC);
		endcase
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_q <= lmzp_pkg::LMZP_IDLE;
			cnt_q <= '0;
		end
		else if (clk_en)
		begin
			unique case (state_q)
				lmzp_pkg::LMZP_IDLE:
				begin
					if (!cmd.cke && cmd.cs_n)
					begin
						state_q <= lmzp_pkg::LMZP_PD;
						cnt_q <= '0;
					end
					else if (is_mrr)
					begin
						state_q <= lmzp_pkg::LMZP_MRR;
						cnt_q <= CW'(`LMZP_RL_CYC + `LMZP_BURST);
					end
					else if (mem_clr)
					begin
						state_q <= lmzp_pkg::LMZP_INIT;
						cnt_q <= CW'(INIT_CYC);
					end
					else if (zq_cmd && op != `LMZP_ZQ_RESET)
					begin
						state_q <= lmzp_pkg::LMZP_ZQ;
						cnt_q <= zq_len;
					end
					else if (is_mrw)
					begin
						state_q <= lmzp_pkg::LMZP_MRW;
						cnt_q <= CW'(MRW_CYC);
					end
				end
				lmzp_pkg::LMZP_MRR, lmzp_pkg::LMZP_MRW, lmzp_pkg::LMZP_INIT,
				lmzp_pkg::LMZP_ZQ, lmzp_pkg::LMZP_XP:
				begin
					if (cnt_q <= CW'(1))
						state_q <= lmzp_pkg::LMZP_IDLE;
					cnt_q <= cnt_q - CW'(1);
				end
				lmzp_pkg::LMZP_PD:
				begin
					if (cnt_q < CW'(CKE_CYC))
						cnt_q <= cnt_q + CW'(1);
					if (cmd.cke && cnt_q >= CW'(CKE_CYC - 1))
					begin
						state_q <= lmzp_pkg::LMZP_XP;
						cnt_q <= CW'(XP_CYC);
					end
				end
				default:
					state_q <= lmzp_pkg::LMZP_IDLE;
			endcase
		end
	end

	// ****************************************************************
	// Read burst and calibration pattern
	// ****************************************************************
	logic [3:0] beats_q;
	logic pat_q;
	logic [1:0] beat_q;
	logic [DQ_W-1:0] dq_d;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			beats_q <= 4'h0;
			pat_q <= 1'b0;
			beat_q <= 2'h0;
		end
		else if (clk_en && is_mrr)
		begin
			pat_q <= is_pat;
			beats_q <= (ma == `LMZP_PAT_A_ADDR) ? `LMZP_PAT_A : `LMZP_PAT_B;
			beat_q <= 2'h0;
		end
		else if (clk_en && state_q == lmzp_pkg::LMZP_MRR && cnt_q <= CW'(`LMZP_BURST))
			beat_q <= beat_q + 2'h1;
	end

	always_comb
	begin
		dq_d = '0;
		if (pat_q)
			dq_d = {DQ_W{beats_q[beat_q]}};
		else if (beat_q == 2'h0)
			dq_d[7:0] = rdata;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			dq_out <= '0;
			dq_oe <= 1'b0;
			pat_beats <= 4'h0;
		end
		else if (clk_en)
		begin
			dq_oe <= state_q == lmzp_pkg::LMZP_MRR && cnt_q <= CW'(`LMZP_BURST);
			dq_out <= dq_d;
			pat_beats <= beats_q;
		end
	end

	// ****************************************************************
	// Status, buffers and calibration pin
	// ****************************************************************
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			stat <= '0;
			refresh_allow <= 1'b1;
			in_buf_en <= 1'b1;
		end
		else if (clk_en)
		begin
			stat.in_pd <= state_q == lmzp_pkg::LMZP_PD;
			if (state_q == lmzp_pkg::LMZP_IDLE && !cmd.cke && cmd.cs_n)
				stat.active_pd <= any_bank_open;
			stat.busy <= state_q != lmzp_pkg::LMZP_IDLE;
			stat.zq_pin_en <= state_q == lmzp_pkg::LMZP_ZQ;
			stat.zq_done <= state_q == lmzp_pkg::LMZP_ZQ && cnt_q <= CW'(1);
			refresh_allow <= state_q != lmzp_pkg::LMZP_PD;
			in_buf_en <= state_q != lmzp_pkg::LMZP_PD;
		end
	end

endmodule : lmzp_core

// ==== lmzp_asserts.sv ====
/* Port checker for lmzp_core.
   Assumes it is bound to every lmzp_core instance. */
`timescale 1ns/1ns
module lmzp_asserts #(parameter int DQ_W = 32) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire lmzp_pkg::lmzp_cmd_t cmd,
	input wire logic any_bank_open,
	input wire logic zq_strap_vdd,
	input wire logic [DQ_W-1:0] dq_out,
	input wire logic dq_oe,
	input wire logic refresh_allow,
	input wire logic in_buf_en,
	input wire lmzp_pkg::lmzp_stat_t stat
);
	// ****
	// Decode
	// ****
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	wire idle = clk_en && !stat.busy && !stat.in_pd;
	wire take = idle && cmd.cke && !cmd.cs_n;
	wire [7:0] ma = {cmd.ca_rise[9:4], cmd.ca_fall[1:0]};
	wire rd = take && cmd.ca_rise[3:0] == 4'h8;
	wire wr = take && cmd.ca_rise[3:0] == 4'h0;
	logic pa_q;
	logic pb_q;
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pa_q <= 1'h0;
			pb_q <= 1'h0;
		end
		else if (rd)
		begin
			pa_q <= ma == 8'h20;
			pb_q <= ma == 8'h28;
		end
	end
	// ****
	// Checks
	// ****
	a_read_burst: assert property (rd |-> ##5 dq_oe [*4])
		else $error("read burst");
	a_pattern_a: assert property ($rose(dq_oe) && pa_q |->
		dq_out[0] ##1 !dq_out[0] ##1 dq_out[0] ##1 !dq_out[0]) else $error("pattern a");
	a_pattern_b: assert property ($rose(dq_oe) && pb_q |->
		!dq_out[0] ##1 !dq_out[0] ##1 dq_out[0] ##1 dq_out[0]) else $error("pattern b");
	a_lane_copy: assert property (dq_oe && (pa_q || pb_q) |-> dq_out == {DQ_W{dq_out[0]}})
		else $error("lane copy");
	a_write_busy: assert property (wr && ma != 8'h0A |=> ##1 stat.busy)
		else $error("write busy");
	a_pd_entry: assert property (idle && !cmd.cke && cmd.cs_n |=> ##1 stat.in_pd)
		else $error("pd entry");
	a_pd_buffers: assert property (stat.in_pd && $past(stat.in_pd) |->
		!refresh_allow && !in_buf_en) else $error("pd buffers");
	a_pd_kind: assert property ($rose(stat.in_pd) |-> stat.active_pd == $past(any_bank_open))
		else $error("pd kind");
	a_strap_ignore: assert property (zq_strap_vdd && wr && ma == 8'h0A |=>
		!stat.zq_pin_en [*6]) else $error("strap");
	cover property (rd && ma == 8'h20);
	cover property (stat.zq_done);
	cover property ($rose(stat.in_pd));
endmodule : lmzp_asserts

bind lmzp_core lmzp_asserts #(.DQ_W(DQ_W)) u_asserts (.clk(clk), .rst_n(rst_n),
	.clk_en(clk_en), .cmd(cmd), .any_bank_open(any_bank_open), .zq_strap_vdd(zq_strap_vdd),
	.dq_out(dq_out), .dq_oe(dq_oe), .refresh_allow(refresh_allow), .in_buf_en(in_buf_en),
	.stat(stat));

// ==== lmzp_host.sv ====
/* Host controller model driving the command bus.
   Assumes clk from the bench; drives at the falling edge. */
`timescale 1ns/1ns
module lmzp_host (
	input wire logic clk,
	input wire lmzp_pkg::lmzp_stat_t stat,
	input wire logic dq_oe,
	input wire logic [31:0] dq_out,
	output lmzp_pkg::lmzp_cmd_t cmd
);
	logic [31:0] beat [4];
	int cyc;
	logic zq_seen;
	logic zq_end;
	initial cmd = {2'h3, 20'h0};
	// ****
	// Commands
	// ****
	task automatic no_operation_cmd(input logic cke);
		@(negedge clk);
		cmd <= {1'h1, cke, 20'($urandom)};
	endtask : no_operation_cmd
	task automatic settle();
		int k;
		k = 0;
		cyc = 0;
		zq_seen = 1'h0;
		zq_end = 1'h0;
		// Busy shows one cycle after the command edge
		no_operation_cmd(1'h1);
		while ((stat.busy || stat.in_pd || dq_oe) && cyc < 300)
		begin
			if (dq_oe)
			begin
				beat[k] = dq_out;
				k++;
			end
			zq_seen |= stat.zq_pin_en;
			zq_end |= stat.zq_done;
			cyc++;
			no_operation_cmd(1'h1);
		end
	endtask : settle
	task automatic issue(input logic [9:0] rise, input logic [9:0] fall);
		@(negedge clk);
		cmd <= {2'h1, rise, fall};
		no_operation_cmd(1'h1);
		settle();
	endtask : issue
	task automatic pd_enter(input int n);
		no_operation_cmd(1'h0);
		no_operation_cmd(1'h0);
		repeat (n)
		begin
			@(negedge clk);
			cmd <= {1'($urandom), 1'h0, 20'($urandom)};
		end
	endtask : pd_enter
endmodule : lmzp_host

// ==== lmzp_tb.sv ====
/* Self-checking bench for lmzp_core with the host model.
   Assumes the design package and header compile first. */
`timescale 1ns/1ns
module testbench;
	logic clk;
	logic rst_n;
	logic clk_en;
	logic any_bank_open;
	logic zq_strap_vdd;
	lmzp_pkg::lmzp_cmd_t cmd;
	lmzp_pkg::lmzp_stat_t stat;
	logic [31:0] dq_out;
	logic dq_oe;
	logic refresh_allow;
	logic in_buf_en;
	logic [3:0] pat_beats;
	logic [7:0] regs [64];
	int err_count = 0;
	int tests_run = 0;
	lmzp_core #(.INIT_CYC(10)) uut (.clk(clk), .rst_n(rst_n), .clk_en(clk_en), .cmd(cmd),
		.any_bank_open(any_bank_open), .zq_strap_vdd(zq_strap_vdd), .dq_out(dq_out),
		.dq_oe(dq_oe), .pat_beats(pat_beats), .refresh_allow(refresh_allow), .in_buf_en(in_buf_en),
		.stat(stat));
	lmzp_host host (.clk(clk), .stat(stat), .dq_oe(dq_oe), .dq_out(dq_out), .cmd(cmd));
	// ****
	// Helpers
	// ****
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			err_count++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	function automatic logic ro(input logic [7:0] ma);
		return (ma >= 8'h04 && ma <= 8'h08) || ma == 8'h20 || ma == 8'h28;
	endfunction : ro
	function automatic logic [31:0] exp_beat(input logic [7:0] ma, input int b);
		logic [3:0] p;
		p = ma == 8'h20 ? 4'h5 : 4'hC;
		return {32{p[b]}};
	endfunction : exp_beat
	task automatic mode_reg_write_cmd(input logic [7:0] ma, input logic [7:0] op);
		host.issue({ma[7:2], 4'h0}, {op, ma[1:0]});
		if (!ro(ma) && clk_en)
			regs[ma[5:0]] = op;
	endtask : mode_reg_write_cmd
	task automatic rd_chk(input logic [7:0] ma);
		host.issue({ma[7:2], 4'h8}, {8'($urandom), ma[1:0]});
		check("read byte", host.beat[0][7:0],
			ma == 8'h20 ? 8'hFF : ro(ma) ? 8'h00 : regs[ma[5:0]]);
		check("read period", host.cyc, 7);
	endtask : rd_chk
	task automatic wrap_up();
		$display("Checks %0d errors %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : wrap_up
	// ****
	// Sequence
	// ****
	initial
	begin
		clk = 1'h0;
		forever #5 clk = ~clk;
	end
	initial
	begin
		#200000;
		err_count++;
		wrap_up();
	end
	initial
	begin
		logic [7:0] a;
		logic [7:0] zop [4];
		int zcyc [4];
		zop = '{8'hFF, 8'hAB, 8'h56, 8'hC3};
		zcyc = '{100, 36, 9, 5};
		void'($urandom(43237));
		rst_n = 1'h0;
		clk_en = 1'h1;
		any_bank_open = 1'h0;
		zq_strap_vdd = 1'h0;
		foreach (regs[i])
			regs[i] = 8'h00;
		repeat (8) @(negedge clk);
		rst_n = 1'h1;
		mode_reg_write_cmd(8'h04, 8'hFF);
		rd_chk(8'h04);
		mode_reg_write_cmd(8'h20, 8'h00);
		for (int i = 0; i < 4; i++)
		begin
			any_bank_open = i[0];
			a = i[1] ? 8'h28 : 8'h20;
			rd_chk(a);
			for (int b = 0; b < 4; b++)
				check("pattern", host.beat[b], exp_beat(a, b));
			check("pattern beats", pat_beats, i[1] ? 4'hC : 4'h5);
		end
		any_bank_open = 1'h0;
		repeat (6)
		begin
			a = 8'h10 + 8'($urandom_range(15));
			mode_reg_write_cmd(a, 8'($urandom));
			check("write period", host.cyc, 5);
			rd_chk(a);
		end
		clk_en = 1'h0;
		mode_reg_write_cmd(a, 8'hA5);
		clk_en = 1'h1;
		rd_chk(a);
		mode_reg_write_cmd(8'h3F, 8'hFC);
		check("reset period", host.cyc, 10);
		foreach (regs[i])
			regs[i] = 8'h00;
		rd_chk(a);
		for (int i = 0; i < 4; i++)
		begin
			mode_reg_write_cmd(8'h0A, zop[i]);
			check("cal period", host.cyc, zcyc[i]);
			check("cal pin", host.zq_seen, i < 3);
			check("cal done", host.zq_end, i < 3);
			check("pin off", stat.zq_pin_en, 1'h0);
		end
		zq_strap_vdd = 1'h1;
		host.no_operation_cmd(1'h1);
		mode_reg_write_cmd(8'h0A, 8'hFF);
		check("strap period", host.cyc, 5);
		check("strap pin", host.zq_seen, 1'h0);
		zq_strap_vdd = 1'h0;
		for (int i = 0; i < 2; i++)
		begin
			any_bank_open = i[0];
			host.pd_enter(3);
			check("pd state", {stat.in_pd, stat.active_pd}, {1'h1, i[0]});
			check("pd buffers", {refresh_allow, in_buf_en}, 2'h0);
			host.no_operation_cmd(1'h1);
			host.settle();
			any_bank_open = 1'h0;
			rd_chk(a);
		end
		wrap_up();
	end
endmodule : testbench
